// ### core/i2rd_pkg.sv
// constants for the two-wire read-path controller
// assumes a 10 MHz system clock and an AXI4-Lite master
package i2rd_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_BUF = 12'hf50;
  localparam logic [11:0] OFF_CTRL = 12'hf54;
  localparam logic [11:0] OFF_STAT = 12'hf58;
  localparam logic [11:0] OFF_MASK = 12'hf5c;
  localparam logic [7:0] BUF_RESET = 8'h00;
  // control fields
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_TXIE = 2;
  localparam int C_NAK = 3;
  // status fields; mask uses the same layout
  localparam int S_RXF = 0;
  localparam int S_NACK = 1;
  localparam int S_TXE = 2;
  localparam int S_ACK = 3;
  localparam int S_BUSY = 4;
  localparam int MASK_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_START = 10'h002,
    ST_TX = 10'h004,
    ST_ACKRX = 10'h008,
    ST_WAITW = 10'h010,
    ST_RX = 10'h020,
    ST_ACKTX = 10'h040,
    ST_WAITR = 10'h080,
    ST_HOLD = 10'h100,
    ST_STOP = 10'h200
  } i2rd_state_t;
endpackage

// ### core/i2rd_ctrl.sv
// two-wire bus master read path with its AXI4-Lite register slave
// assumes open-drain pads outside; scl and sda inputs are asynchronous
`timescale 1ns/1ns

module i2rd_ctrl #(
  parameter int QTR = i2rd_pkg::QTR_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);
  initial begin
    if (QTR < 1 || QTR > 255) begin
      $error("QTR out of range");
    end
  end

  function automatic logic is_mapped(input logic [11:0] a);
    return a == i2rd_pkg::OFF_BUF || a == i2rd_pkg::OFF_CTRL ||
           a == i2rd_pkg::OFF_STAT || a == i2rd_pkg::OFF_MASK;
  endfunction

  i2rd_pkg::i2rd_state_t state, next_state;
  logic [7:0] data_buf;
  logic [7:0] shifter;
  logic [2:0] bit_cnt;
  logic [1:0] q;
  logic [7:0] tick_cnt;
  logic ctrl_start, ctrl_stop, ctrl_txie, ctrl_nak;
  logic rx_full, nack_flag, tx_empty, ack_stat, rd_mode, addr_phase;
  logic ack_seen;
  logic [i2rd_pkg::MASK_W-1:0] irq_mask;
  logic scl_m, scl_s, sda_m, sda_s;

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge aclk) begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    sda_m <= sda_in;
    sda_s <= sda_m;
  end

  // ---------------- AXI4-Lite slave ----------------
  logic aw_have, w_have;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_go = s_axi_awvalid & s_axi_awready;
  wire w_go = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire next_aw_have = (aw_have | aw_go) & ~wr_fire;
  wire next_w_have = (w_have | w_go) & ~wr_fire;
  wire next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  wire wr_lane = wr_fire & w_strb[0];
  wire wr_buf = wr_lane & (aw_addr == i2rd_pkg::OFF_BUF);
  wire wr_ctrl = wr_lane & (aw_addr == i2rd_pkg::OFF_CTRL);
  wire wr_stat = wr_lane & (aw_addr == i2rd_pkg::OFF_STAT);
  wire wr_mask = wr_lane & (aw_addr == i2rd_pkg::OFF_MASK);
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = rd_fire | (s_axi_rvalid & ~s_axi_rready);
  wire rd_buf = rd_fire & (s_axi_araddr == i2rd_pkg::OFF_BUF);

  wire [7:0] ctrl_word = {4'h0, ctrl_nak, ctrl_txie, ctrl_stop, ctrl_start};
  wire busy = state != i2rd_pkg::ST_IDLE;
  wire [7:0] stat_word = {3'h0, busy, ack_stat, tx_empty, nack_flag, rx_full};
  wire [7:0] rd_word =
    (s_axi_araddr == i2rd_pkg::OFF_BUF) ? data_buf :
    (s_axi_araddr == i2rd_pkg::OFF_CTRL) ? ctrl_word :
    (s_axi_araddr == i2rd_pkg::OFF_STAT) ? stat_word :
    (s_axi_araddr == i2rd_pkg::OFF_MASK) ? {5'h00, irq_mask} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= i2rd_pkg::RESP_OKAY;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      if (aw_go) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_go) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~next_aw_have & ~next_bvalid;
      s_axi_wready <= ~next_w_have & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= is_mapped(aw_addr) ? i2rd_pkg::RESP_OKAY
                                          : i2rd_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= i2rd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (rd_fire) begin
        s_axi_rdata <= {24'h00_0000, rd_word};
        s_axi_rresp <= is_mapped(s_axi_araddr) ? i2rd_pkg::RESP_OKAY
                                               : i2rd_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------- bit timing ----------------
  // each bit is four quarters; quarter 1 waits for scl to read high,
  // which lets a slave stretch the clock
  wire quarter_done = (tick_cnt == 8'(QTR - 1)) &&
                      (q != 2'h1 || scl_s);
  wire bit_end = quarter_done && q == i2rd_pkg::Q_LAST;
  wire sample = quarter_done && q == i2rd_pkg::Q_SAMPLE;
  wire timed = state == i2rd_pkg::ST_START || state == i2rd_pkg::ST_TX ||
               state == i2rd_pkg::ST_ACKRX || state == i2rd_pkg::ST_RX ||
               state == i2rd_pkg::ST_ACKTX || state == i2rd_pkg::ST_STOP;
  wire scl_hi_q = q == 2'h1 || q == 2'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn || !timed || state != next_state) begin
      tick_cnt <= 8'h00;
      q <= 2'h0;
    end else if (quarter_done) begin
      tick_cnt <= 8'h00;
      q <= q + 2'h1;
    end else if (q != 2'h1 || scl_s) begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  // ---------------- sequencer ----------------
  wire start_end = state == i2rd_pkg::ST_START && bit_end;
  wire stop_end = state == i2rd_pkg::ST_STOP && bit_end;
  wire acktx_end = state == i2rd_pkg::ST_ACKTX && bit_end;
  wire ackrx_end = state == i2rd_pkg::ST_ACKRX && bit_end;
  wire load_next = state == i2rd_pkg::ST_WAITW && !ctrl_stop &&
                   !ctrl_start && !tx_empty;
  wire addr_nack = ackrx_end && !ack_seen;
  wire final_nack = acktx_end && ctrl_nak;

  always_comb begin
    next_state = state;
    case (state)
      i2rd_pkg::ST_IDLE: begin
        if (ctrl_start) next_state = i2rd_pkg::ST_START;
      end
      i2rd_pkg::ST_START: begin
        if (bit_end) next_state = i2rd_pkg::ST_TX;
      end
      i2rd_pkg::ST_TX: begin
        if (bit_end && bit_cnt == i2rd_pkg::BIT_LAST) begin
          next_state = i2rd_pkg::ST_ACKRX;
        end
      end
      i2rd_pkg::ST_ACKRX: begin
        if (bit_end) begin
          if (!ack_seen) next_state = i2rd_pkg::ST_HOLD;
          else if (addr_phase && rd_mode) next_state = i2rd_pkg::ST_RX;
          else next_state = i2rd_pkg::ST_WAITW;
        end
      end
      i2rd_pkg::ST_WAITW: begin
        // repeated start picks up the read-direction prefix byte
        if (ctrl_stop) next_state = i2rd_pkg::ST_STOP;
        else if (ctrl_start) next_state = i2rd_pkg::ST_START;
        else if (!tx_empty) next_state = i2rd_pkg::ST_TX;
      end
      i2rd_pkg::ST_RX: begin
        if (bit_end && bit_cnt == i2rd_pkg::BIT_LAST) begin
          next_state = i2rd_pkg::ST_ACKTX;
        end
      end
      i2rd_pkg::ST_ACKTX: begin
        if (bit_end) begin
          next_state = ctrl_nak ? i2rd_pkg::ST_HOLD
                                : i2rd_pkg::ST_WAITR;
        end
      end
      i2rd_pkg::ST_WAITR: begin
        if (ctrl_stop) next_state = i2rd_pkg::ST_STOP;
        else if (!rx_full) next_state = i2rd_pkg::ST_RX;
      end
      i2rd_pkg::ST_HOLD: begin
        if (ctrl_stop) next_state = i2rd_pkg::ST_STOP;
      end
      i2rd_pkg::ST_STOP: begin
        if (bit_end) next_state = i2rd_pkg::ST_IDLE;
      end
      default: next_state = i2rd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state <= i2rd_pkg::ST_IDLE;
    else state <= next_state;
  end

  // shift register: internal only, no decode reaches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifter <= 8'h00;
      bit_cnt <= 3'h0;
      ack_seen <= 1'b0;
    end else begin
      if (start_end || load_next) begin
        shifter <= data_buf;
        bit_cnt <= 3'h0;
      end else if (state == i2rd_pkg::ST_TX && bit_end) begin
        shifter <= {shifter[6:0], 1'b0};
        bit_cnt <= bit_cnt + 3'h1;
      end else if (state == i2rd_pkg::ST_RX && sample) begin
        shifter <= {shifter[6:0], sda_s};
      end else if (state == i2rd_pkg::ST_RX && bit_end) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (state == i2rd_pkg::ST_ACKRX && sample) ack_seen <= !sda_s;
    end
  end

  // direction comes from bit 0 of the byte sent after a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_mode <= 1'b0;
      addr_phase <= 1'b0;
      ack_stat <= 1'b0;
    end else begin
      if (start_end) begin
        rd_mode <= data_buf[0];
        addr_phase <= 1'b1;
      end else if (ackrx_end) begin
        addr_phase <= 1'b0;
      end
      if (ackrx_end) ack_stat <= ack_seen;
    end
  end

  // data buffer: written by software, filled from the shifter on reads
  always_ff @(posedge aclk) begin
    if (!aresetn) data_buf <= i2rd_pkg::BUF_RESET;
    else if (acktx_end) data_buf <= shifter;
    else if (wr_buf) data_buf <= w_data[7:0];
  end

  // hardware set wins over any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full <= 1'b0;
      nack_flag <= 1'b0;
      tx_empty <= 1'b0;
    end else begin
      if (acktx_end) rx_full <= 1'b1;
      else if (rd_buf) rx_full <= 1'b0;
      if (addr_nack || final_nack) nack_flag <= 1'b1;
      else if (stop_end) nack_flag <= 1'b0;
      else if (wr_stat && w_data[i2rd_pkg::S_NACK]) nack_flag <= 1'b0;
      if (start_end || load_next) tx_empty <= 1'b1;
      else if (wr_buf) tx_empty <= 1'b0;
    end
  end

  // software sets start/stop; the sequencer clears them when done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_start <= 1'b0;
      ctrl_stop <= 1'b0;
      ctrl_txie <= 1'b0;
      ctrl_nak <= 1'b0;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_start <= w_data[i2rd_pkg::C_START];
        ctrl_stop <= w_data[i2rd_pkg::C_STOP];
        ctrl_txie <= w_data[i2rd_pkg::C_TXIE];
        ctrl_nak <= w_data[i2rd_pkg::C_NAK];
      end else begin
        if (start_end) ctrl_start <= 1'b0;
        if (stop_end) begin
          ctrl_stop <= 1'b0;
          ctrl_nak <= 1'b0;
        end
      end
      if (wr_mask) irq_mask <= w_data[i2rd_pkg::MASK_W-1:0];
    end
  end

  // ---------------- pins and interrupt ----------------
  logic next_scl_rel, next_sda_rel;
  always_comb begin
    next_scl_rel = 1'b0;
    next_sda_rel = 1'b1;
    case (state)
      i2rd_pkg::ST_IDLE: next_scl_rel = 1'b1;
      i2rd_pkg::ST_START: begin
        next_scl_rel = scl_hi_q;
        next_sda_rel = q < i2rd_pkg::Q_SAMPLE;
      end
      i2rd_pkg::ST_TX: begin
        next_scl_rel = scl_hi_q;
        next_sda_rel = shifter[7];
      end
      i2rd_pkg::ST_ACKRX, i2rd_pkg::ST_RX: next_scl_rel = scl_hi_q;
      i2rd_pkg::ST_ACKTX: begin
        next_scl_rel = scl_hi_q;
        next_sda_rel = ctrl_nak;
      end
      i2rd_pkg::ST_STOP: begin
        next_scl_rel = q != 2'h0;
        next_sda_rel = q == i2rd_pkg::Q_LAST;
      end
      default: next_sda_rel = 1'b1;
    endcase
  end

  // pads only ever pull low; release lets the pull-up win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      scl_oe_n <= next_scl_rel;
      sda_oe_n <= next_sda_rel;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      irq <= |({tx_empty & ctrl_txie, nack_flag, rx_full} & irq_mask);
    end
  end
endmodule

// ### sim/i2rd_chk.sv
// port assertions for the two-wire read-path controller
// assumes the port names of i2rd_ctrl; bound to every instance
`timescale 1ns/1ns
module i2rd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time)
    else $error("write response late");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_time: assert property (p_r_time)
    else $error("read answer late");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:4] != 8'hf5
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_byte_wide;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("read data wider than a byte");
  property p_drain;
    !scl_out && !sda_out;
  endproperty
  a_drain: assert property (p_drain)
    else $error("pin driven high");
  // a slave holding the clock low must not be overridden
  property p_stretch;
    scl_oe_n && !scl_in |=> scl_oe_n;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock pulled while stretched");
  property p_start;
    $fell(sda_oe_n) && scl_oe_n |-> ##[1:20] !scl_oe_n;
  endproperty
  a_start: assert property (p_start)
    else $error("start not followed by clock");
  property p_stop;
    $rose(sda_oe_n) && scl_oe_n && scl_in |=> (sda_oe_n && scl_oe_n)[*4];
  endproperty
  a_stop: assert property (p_stop)
    else $error("bus not left after stop");
endmodule
bind i2rd_ctrl i2rd_chk u_chk (.*);

// ### sim/i2rd_slave.sv
// behavioural two-wire slave: acks writes, sends counting bytes on reads
// assumes pull-up wires built by the bench from all pull requests
`timescale 1ns/1ns
module i2rd_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic refuse,
  input wire logic slow,
  output logic pull,
  output logic hold
);
  logic [7:0] sh;
  logic [7:0] dat;
  logic rd;
  logic addr;
  logic mack;
  int n;
  initial begin
    pull = 0;
    hold = 0;
    rd = 0;
    addr = 0;
    n = 0;
    dat = 8'ha5;
  end
  // the start's own clock fall must not count as a bit
  always @(negedge sda) if (scl) begin
    n = -1;
    addr = 1;
    rd = 0;
  end
  always @(posedge sda) if (scl) begin
    rd = 0;
    addr = 0;
  end
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    else mack = !sda;
  end
  always @(negedge scl) begin
    pull = 0;
    if (n == 8) begin
      if (rd) begin
        dat = dat + 8'h01;
        rd = mack;
      end else if (addr && sh[0]) rd = 1;
      addr = 0;
      n = 0;
    end else n = n + 1;
    if (n == 8 && !rd) pull = !(refuse && addr);
    if (rd && n < 8) pull = !dat[7 - n];
    if (slow) begin
      hold = 1;
      #300 hold = 0;
    end
  end
endmodule

// ### sim/test_i2c_master_read_path.sv
// bench for the read-path controller: AXI4-Lite tasks, slave model
// assumes i2rd_ctrl with its default quarter length
`timescale 1ns/1ns
module test_i2c_master_read_path;
  logic aclk, aresetn, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic refuse, slow, pull, hold;
  logic [8:0] sr;
  logic [8:0] seen[$];
  logic [8:0] exp9[7];
  int errors, checked, nbit, starts, stops, i;
  // pull-up lines: low only while someone pulls
  wire scl_in = (scl_oe_n !== 1'b0) && !hold;
  wire sda_in = (sda_oe_n !== 1'b0) && !pull;
  i2rd_ctrl u_dut (.*);
  i2rd_slave u_slave (.scl(scl_in), .sda(sda_in), .refuse(refuse),
    .slow(slow), .pull(pull), .hold(hold));
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  // lines settle from unknown at time zero; count only once out of reset
  always @(negedge sda_in) if (scl_in && aresetn === 1'b1) begin
    starts++;
    nbit = 0;
  end
  always @(posedge sda_in) if (scl_in && aresetn === 1'b1) stops++;
  always @(posedge scl_in) begin
    sr = {sr[7:0], sda_in};
    if (nbit == 8) seen.push_back(sr);
    nbit = (nbit == 8) ? 0 : nbit + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    got = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // bounded polling of one status bit
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      rd(i2rd_pkg::OFF_STAT);
      k++;
    end while (got[b] !== v && k < 500);
  endtask
  task automatic wirq;
    int k;
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    tally_and_finish;
  end
  initial begin
    exp9 = '{{8'hf2, 1'b1}, {8'hf2, 1'b0}, {8'h3c, 1'b0}, {8'hf3, 1'b0},
      {8'ha5, 1'b0}, {8'ha6, 1'b0}, {8'ha7, 1'b1}};
    s_axi_awvalid = 0;
    s_axi_wvalid = 0;
    s_axi_bready = 0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hf;
    refuse = 0;
    slow = 0;
    aresetn = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(i2rd_pkg::OFF_BUF);
    chk(got, 32'h0);
    rd(12'hf60);
    chk({30'h0, resp}, 32'h2);
    wr(12'hf60, 8'hff);
    chk({30'h0, resp}, 32'h2);
    s_axi_wstrb <= 4'he;
    wr(i2rd_pkg::OFF_BUF, 8'h5a);
    chk({30'h0, resp}, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(i2rd_pkg::OFF_BUF);
    chk(got, 32'h0);
    $display("test register map done");
    refuse = 1;
    wr(i2rd_pkg::OFF_MASK, 8'h00);
    wr(i2rd_pkg::OFF_BUF, 8'hf2);
    wr(i2rd_pkg::OFF_CTRL, 8'h05);
    poll(i2rd_pkg::S_NACK, 1'b1);
    chk(got & 32'ha, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(i2rd_pkg::OFF_MASK, 8'h02);
    wirq;
    chk({31'h0, irq}, 32'h1);
    wr(i2rd_pkg::OFF_CTRL, 8'h02);
    poll(i2rd_pkg::S_NACK, 1'b0);
    chk(got & 32'h2, 32'h0);
    rd(i2rd_pkg::OFF_CTRL);
    chk(got & 32'h2, 32'h0);
    chk({30'h0, scl_in, sda_in}, 32'h3);
    wr(i2rd_pkg::OFF_MASK, 8'h04);
    wr(i2rd_pkg::OFF_CTRL, 8'h04);
    wirq;
    chk({31'h0, irq}, 32'h1);
    wr(i2rd_pkg::OFF_CTRL, 8'h00);
    $display("test address refusal done");
    refuse = 0;
    slow = 1;
    wr(i2rd_pkg::OFF_MASK, 8'h01);
    wr(i2rd_pkg::OFF_BUF, 8'hf2);
    wr(i2rd_pkg::OFF_CTRL, 8'h05);
    poll(i2rd_pkg::S_TXE, 1'b1);
    chk(got & 32'h4, 32'h4);
    wr(i2rd_pkg::OFF_BUF, 8'h3c);
    poll(i2rd_pkg::S_TXE, 1'b1);
    wr(i2rd_pkg::OFF_BUF, 8'hf3);
    wr(i2rd_pkg::OFF_CTRL, 8'h05);
    for (i = 0; i < 3; i++) begin
      wirq;
      chk({31'h0, irq}, 32'h1);
      rd(i2rd_pkg::OFF_BUF);
      chk(got, 32'ha5 + 32'(i));
      if (i == 1) wr(i2rd_pkg::OFF_CTRL, 8'h0c);
      rd(i2rd_pkg::OFF_STAT);
      chk(got & 32'h3, (i == 2) ? 32'h2 : 32'h0);
    end
    wr(i2rd_pkg::OFF_CTRL, 8'h02);
    poll(i2rd_pkg::S_NACK, 1'b0);
    chk(got & 32'h2, 32'h0);
    chk(32'(starts), 32'd3);
    chk(32'(stops), 32'd2);
    chk(32'(seen.size()), 32'd7);
    foreach (exp9[k]) chk({23'h0, seen[k]}, {23'h0, exp9[k]});
    $display("test ten-bit read done");
    tally_and_finish;
  end
endmodule
